// [logic/bchs_pkg.sv]
// constants shared by the bearer/channel host switch and its write-register store
package bchs_pkg;
    // frame layout: 32 bits per terminal-bus frame, sent msb first
    localparam int FRAME_BITS = 32;
    localparam int NCH        = 5;
    // channel order: 0 first bearer, 1 second bearer, 2 monitor, 3 signalling, 4 command
    localparam int CH_HI [NCH] = '{31, 23, 15, 7, 5};
    localparam int CH_W  [NCH] = '{8, 8, 8, 2, 4};
    localparam logic [1:0] IDLE_TAIL = 2'h3;
    // switch-select bit positions (bit 7 watchdog, 1 and 0 s/g control are storage only)
    localparam int SEL_BIT [NCH] = '{6, 5, 2, 4, 3};
    // interrupt status bit positions
    localparam int ST_B1 = 0;
    localparam int ST_B2 = 1;
    // host port word indices
    localparam logic [5:0] A_SWSEL   = 6'h00;
    localparam logic [5:0] A_STATUS  = 6'h01;
    localparam logic [5:0] A_CFG     = 6'h02;
    localparam logic [5:0] A_CORE_TX = 6'h10; // plus channel, entries 0..4 of the store
    localparam logic [5:0] A_BUS_TX  = 6'h18; // plus channel, entries 8..12 of the store
    localparam logic [5:0] A_CORE_RX = 6'h20; // plus channel
    localparam logic [5:0] A_BUS_RX  = 6'h28; // plus channel
    localparam logic [5:0] A_WIN_MSK = 6'h38;
    localparam logic [5:0] A_CH_MSK  = 6'h07;
    // reset values
    localparam logic [7:0] SWSEL_RST = 8'h00;
    localparam logic [7:0] CFG_RST   = 8'h00;
    localparam logic [7:0] DATA_RST  = 8'hFF;
    localparam logic [3:0] CI_SW_RESET = 4'h1;
    // store geometry
    localparam int MEM_DEPTH = 16;
    localparam int MEM_AW    = 4;
    // timing
    localparam int SYS_PERIOD_NS = 20;
    localparam int FRAME_US      = 125;
    localparam int CLK_LOSS_NS   = 1000;
    localparam int CLK_LOSS_CYC  = CLK_LOSS_NS / SYS_PERIOD_NS;
    localparam logic [7:0] CLK_LOSS_MAX = 8'(CLK_LOSS_CYC);
endpackage

// [logic/bchs_switch.sv]
// host switch between the terminal bus and the transceiver core
// Summary of operation
// - set path bit routes channel through registers
// - clear path bit passes channel straight through
// - hardware reset clears switch-select to zero
// - bearer path bit gives host bearer access
// - four byte registers per bearer channel
// - routed bearer arrival sets its interrupt flag
// - first flag clears after both reads
// - second flag clears after both reads
// - read registers stable one frame after flag
// - master mode works without bus
// - host joins the monitor channel
// - pin reset spares startup config
// - power-on reset also clears config, data registers load FF
// - command code 0001 resets core only
// - core reset covers all core parts
// - slave mode core reset waits for clocks
`timescale 1ns/1ps
module bchs_switch
    import bchs_pkg::*;
(
    input  wire logic                  i_sys_clk,
    input  wire logic                  i_sys_rst,
    input  wire logic                  i_reset_input_pin_n,
    input  wire logic                  i_bus_slave_mode,
    input  wire logic                  i_bus_dclk,
    input  wire logic                  i_bus_fsync,
    input  wire logic                  i_bus_din,
    output logic                       o_bus_dout,
    input  wire logic [5:0]            i_host_addr,
    input  wire logic [7:0]            i_host_wdata,
    input  wire logic                  i_host_wr,
    input  wire logic                  i_host_rd,
    output logic      [7:0]            o_host_rdata,
    input  wire logic [FRAME_BITS-1:0] i_core_rx_frame,
    output logic      [FRAME_BITS-1:0] o_core_tx_frame,
    output logic                       o_core_frame_stb,
    output logic                       o_core_reset
);
    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers: clock, frame sync, data, reset pin
    logic [3:0] pin_raw;
    logic [3:0] sync1_r;
    logic [3:0] sync2_r;
    logic [3:0] sync3_r;
    assign pin_raw = {i_reset_input_pin_n, i_bus_din, i_bus_fsync, i_bus_dclk};
    localparam logic [3:0] PIN_IDLE = 4'hC; // clock and sync idle low, data and reset pin high
    genvar p;
    generate
        for (p = 0; p < 4; p++) begin : g_sync
            // flops reset to the pin's idle level, so no false edge or reset follows
            always_ff @(posedge i_sys_clk) begin
                if (i_sys_rst) begin
                    sync1_r[p] <= PIN_IDLE[p];
                    sync2_r[p] <= PIN_IDLE[p];
                    sync3_r[p] <= PIN_IDLE[p];
                end else begin
                    sync1_r[p] <= pin_raw[p];
                    sync2_r[p] <= sync1_r[p];
                    sync3_r[p] <= sync2_r[p];
                end
            end
        end
    endgenerate

    wire dclk_rise = sync2_r[0] & ~sync3_r[0];
    wire dclk_fall = ~sync2_r[0] & sync3_r[0];
    wire fsync_s   = sync2_r[1];
    wire din_s     = sync2_r[2];
    wire hw_rst    = ~sync2_r[3]; // pin reset, active low at the pin
    wire reg_rst   = i_sys_rst | hw_rst;

    ////////////////////////////////////////////////////////////////////////////
    // bus bit timing: shift out on rising, sample on falling
    logic [4:0]            bit_cnt_r;
    logic [FRAME_BITS-1:0] rx_shift_r;
    logic [FRAME_BITS-1:0] bus_frame_r;
    logic [FRAME_BITS-1:0] tx_bus_r;
    logic                  frame_done_r;
    logic                  dout_r;
    wire  [4:0]            bit_cnt_nxt = fsync_s ? 5'h00 : 5'(bit_cnt_r + 5'h01);
    wire  [FRAME_BITS-1:0] rx_nxt      = {rx_shift_r[FRAME_BITS-2:0], din_s};
    wire                   last_bit    = dclk_fall && bit_cnt_r == 5'h1F;

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            bit_cnt_r <= 5'h00;
            dout_r    <= 1'b1;
        end else if (dclk_rise) begin
            bit_cnt_r <= bit_cnt_nxt;
            dout_r    <= tx_bus_r[~bit_cnt_nxt];
        end
    end

    // frame capture; the frame is complete on the falling edge of bit 31
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            rx_shift_r   <= '1;
            bus_frame_r  <= '1;
            frame_done_r <= 1'b0;
        end else begin
            frame_done_r <= last_bit;
            if (dclk_fall)
                rx_shift_r <= rx_nxt;
            if (last_bit)
                bus_frame_r <= rx_nxt;
        end
    end
    assign o_bus_dout = dout_r;

    ////////////////////////////////////////////////////////////////////////////
    // host registers held here
    logic [7:0] swsel_r;
    logic [7:0] cfg_r;
    logic [1:0] interrupt_status_r;
    logic [1:0] seen_core_r;
    logic [1:0] seen_bus_r;
    wire        wr_swsel = i_host_wr && i_host_addr == A_SWSEL;
    wire        wr_cfg   = i_host_wr && i_host_addr == A_CFG;
    wire        in_ctx   = (i_host_addr & A_WIN_MSK) == A_CORE_TX;
    wire        in_btx   = (i_host_addr & A_WIN_MSK) == A_BUS_TX;
    wire        in_crx   = (i_host_addr & A_WIN_MSK) == A_CORE_RX;
    wire        in_brx   = (i_host_addr & A_WIN_MSK) == A_BUS_RX;
    wire [2:0]  ch_idx   = i_host_addr[2:0];
    wire        ch_ok    = ch_idx < 3'(NCH);

    // hardware reset clears switch-select, only power-on clears config
    always_ff @(posedge i_sys_clk) begin
        if (reg_rst)
            swsel_r <= SWSEL_RST;
        else if (wr_swsel)
            swsel_r <= i_host_wdata;
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst)
            cfg_r <= CFG_RST;
        else if (wr_cfg)
            cfg_r <= i_host_wdata;
    end

    ////////////////////////////////////////////////////////////////////////////
    // write registers live in the store: core side 0..4, bus side 8..12
    logic [7:0]             mem_rdata;
    logic [MEM_DEPTH*8-1:0] mem_all;
    wire                    mem_wr    = i_host_wr && (in_ctx || in_btx) && ch_ok;
    wire [MEM_AW-1:0]       mem_waddr = {in_btx, i_host_addr[2:0]};

    bchs_wr_mem u_wr_mem (
        .i_sys_clk (i_sys_clk),
        .i_sys_rst (reg_rst),
        .i_wr      (mem_wr),
        .i_waddr   (mem_waddr),
        .i_wdata   (i_host_wdata),
        .i_raddr   (mem_waddr),
        .o_rdata   (mem_rdata),
        .o_all     (mem_all)
    );

    ////////////////////////////////////////////////////////////////////////////
    // per channel: capture, route and rebuild both outgoing frames
    logic [7:0]            core_rx_r [NCH];
    logic [7:0]            bus_rx_r  [NCH];
    logic [NCH-1:0]        path;
    logic [FRAME_BITS-1:0] tx_core_nxt;
    logic [FRAME_BITS-1:0] tx_bus_nxt;
    assign tx_core_nxt[1:0] = IDLE_TAIL;
    assign tx_bus_nxt[1:0]  = IDLE_TAIL;

    genvar c;
    generate
        for (c = 0; c < NCH; c++) begin : g_ch
            localparam int LO = CH_HI[c] - CH_W[c] + 1;
            localparam logic [7:0] MSK = 8'((1 << CH_W[c]) - 1);
            wire [FRAME_BITS-1:0] bus_sh  = bus_frame_r >> LO;
            wire [FRAME_BITS-1:0] core_sh = i_core_rx_frame >> LO;
            wire [7:0] bus_fld  = bus_sh[7:0] & MSK;
            wire [7:0] core_fld = core_sh[7:0] & MSK;
            wire [7:0] wr_core  = mem_all[c*8 +: 8];
            wire [7:0] wr_bus   = mem_all[(c+8)*8 +: 8];
            assign path[c] = swsel_r[SEL_BIT[c]];
            // routed: host bytes go out again every frame until rewritten
            assign tx_core_nxt[CH_HI[c] -: CH_W[c]] =
                path[c] ? wr_core[CH_W[c]-1:0] : bus_fld[CH_W[c]-1:0];
            assign tx_bus_nxt[CH_HI[c] -: CH_W[c]] =
                path[c] ? wr_bus[CH_W[c]-1:0] : core_fld[CH_W[c]-1:0];
            // read registers only move at frame end, so they hold a frame
            always_ff @(posedge i_sys_clk) begin
                if (reg_rst) begin
                    core_rx_r[c] <= DATA_RST;
                    bus_rx_r[c]  <= DATA_RST;
                end else if (frame_done_r && path[c]) begin
                    core_rx_r[c] <= core_fld;
                    bus_rx_r[c]  <= bus_fld;
                end
            end
        end
    endgenerate

    // outgoing frames are refreshed once per frame
    logic core_stb_r;
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            tx_bus_r        <= '1;
            o_core_tx_frame <= '1;
            core_stb_r      <= 1'b0;
        end else begin
            core_stb_r <= frame_done_r;
            if (frame_done_r) begin
                tx_bus_r        <= tx_bus_nxt;
                o_core_tx_frame <= tx_core_nxt;
            end
        end
    end
    assign o_core_frame_stb = core_stb_r;

    ////////////////////////////////////////////////////////////////////////////
    // bearer flags: arrival wins over a clear landing in the same cycle
    wire rd_crx = i_host_rd && in_crx;
    wire rd_brx = i_host_rd && in_brx;
    genvar b;
    generate
        for (b = 0; b < 2; b++) begin : g_flag
            wire arrive = frame_done_r && path[b];
            wire done   = seen_core_r[b] && seen_bus_r[b];
            always_ff @(posedge i_sys_clk) begin
                if (reg_rst) begin
                    interrupt_status_r[b]      <= 1'b0;
                    seen_core_r[b] <= 1'b0;
                    seen_bus_r[b]  <= 1'b0;
                end else if (arrive) begin
                    interrupt_status_r[b]      <= 1'b1;
                    seen_core_r[b] <= 1'b0;
                    seen_bus_r[b]  <= 1'b0;
                end else if (done) begin
                    interrupt_status_r[b]      <= 1'b0;
                    seen_core_r[b] <= 1'b0;
                    seen_bus_r[b]  <= 1'b0;
                end else begin
                    if (rd_crx && ch_idx == 3'(b) && interrupt_status_r[b])
                        seen_core_r[b] <= 1'b1;
                    if (rd_brx && ch_idx == 3'(b) && interrupt_status_r[b])
                        seen_bus_r[b] <= 1'b1;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // host read data: store reads land one cycle later, so the mux is registered
    logic [7:0] loc_rdata_r;
    logic       from_mem_r;
    wire  [7:0] loc_rdata_nxt =
        (i_host_addr == A_SWSEL)  ? swsel_r :
        (i_host_addr == A_STATUS) ? {6'h00, interrupt_status_r} :
        (i_host_addr == A_CFG)    ? cfg_r :
        (in_crx && ch_ok)         ? core_rx_r[ch_idx] :
        (in_brx && ch_ok)         ? bus_rx_r[ch_idx] : 8'h00;

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            loc_rdata_r <= 8'h00;
            from_mem_r  <= 1'b0;
        end else if (i_host_rd) begin
            loc_rdata_r <= loc_rdata_nxt;
            from_mem_r  <= (in_ctx || in_btx) && ch_ok;
        end
    end
    assign o_host_rdata = from_mem_r ? mem_rdata : loc_rdata_r;

    ////////////////////////////////////////////////////////////////////////////
    // core reset: bus clock watch, pending request, gated release
    logic [7:0] idle_cnt_r;
    logic       rst_pend_r;
    logic       core_rst_r;
    wire        clk_present = idle_cnt_r < CLK_LOSS_MAX;
    wire        sw_reset    = frame_done_r && tx_core_nxt[5:2] == CI_SW_RESET;
    // master mode never waits, so host access works with no bus fitted
    wire        may_reset   = !i_bus_slave_mode || clk_present;

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst)
            idle_cnt_r <= CLK_LOSS_MAX;
        else if (dclk_rise || dclk_fall)
            idle_cnt_r <= 8'h00;
        else if (idle_cnt_r < CLK_LOSS_MAX)
            idle_cnt_r <= 8'(idle_cnt_r + 8'h01);
    end

    // one pulse resets coefficients, wake-up, monitor procedure and state machine
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            rst_pend_r <= 1'b1;
            core_rst_r <= 1'b0;
        end else begin
            core_rst_r <= rst_pend_r && may_reset && !hw_rst;
            if (hw_rst || sw_reset)
                rst_pend_r <= 1'b1;
            else if (may_reset)
                rst_pend_r <= 1'b0;
        end
    end
    assign o_core_reset = core_rst_r;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_sys_rst);

    sequence s_b1_both_read;
        seen_core_r[0] && seen_bus_r[0] && !frame_done_r;
    endsequence

    chk_swsel_hw_clear: assert property (hw_rst |=> swsel_r == SWSEL_RST)
        else $error("switch-select not cleared by pin reset");
    chk_cfg_survives: assert property (hw_rst && !wr_cfg |=> cfg_r == $past(cfg_r))
        else $error("startup config changed by pin reset");
    chk_b1_flag_set: assert property (frame_done_r && path[0] && !hw_rst |=> interrupt_status_r[0])
        else $error("first bearer flag not set on arrival");
    chk_b1_flag_clear: assert property ((s_b1_both_read and !hw_rst) |=> !interrupt_status_r[0])
        else $error("first bearer flag not cleared after both reads");
    chk_b2_clear_cause: assert property ($fell(interrupt_status_r[1]) && !$past(hw_rst)
                                         |-> $past(seen_core_r[1] && seen_bus_r[1]))
        else $error("second bearer flag cleared without both reads");
    chk_rx_hold: assert property (!frame_done_r && !hw_rst
                                  |=> $stable(core_rx_r[0]) && $stable(bus_rx_r[0]))
        else $error("first bearer read data moved between frames");
    chk_pass_b1: assert property (frame_done_r && !path[0]
                                  |=> o_core_tx_frame[31:24] == $past(bus_frame_r[31:24]))
        else $error("first bearer not passed straight to core");
    chk_route_b1: assert property (frame_done_r && path[0]
                                   |=> o_core_tx_frame[31:24] == $past(mem_all[7:0]))
        else $error("first bearer not taken from host register");
    chk_slave_wait: assert property (o_core_reset |-> $past(may_reset))
        else $error("core reset issued without bus clocks in slave mode");
    chk_sw_reset: assert property (sw_reset && !i_bus_slave_mode |=> ##1 o_core_reset)
        else $error("command code did not reset the core");
endmodule

// [logic/bchs_wr_mem.sv]
// byte store for the host write registers, with registered read and a parallel view
`timescale 1ns/1ps
module bchs_wr_mem
    import bchs_pkg::*;
(
    input  wire logic                     i_sys_clk,
    input  wire logic                     i_sys_rst,
    input  wire logic                     i_wr,
    input  wire logic [MEM_AW-1:0]        i_waddr,
    input  wire logic [7:0]               i_wdata,
    input  wire logic [MEM_AW-1:0]        i_raddr,
    output logic      [7:0]               o_rdata,
    output logic      [MEM_DEPTH*8-1:0]   o_all
);
    logic [7:0] mem_r [MEM_DEPTH];

    ////////////////////////////////////////////////////////////////////////////
    // one byte per entry; the frame logic sees every entry at once
    genvar g;
    generate
        for (g = 0; g < MEM_DEPTH; g++) begin : g_ent
            always_ff @(posedge i_sys_clk) begin
                if (i_sys_rst)
                    mem_r[g] <= DATA_RST;
                else if (i_wr && i_waddr == MEM_AW'(g))
                    mem_r[g] <= i_wdata;
            end
            assign o_all[g*8 +: 8] = mem_r[g];
        end
    endgenerate

    // registered read port for the host
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst)
            o_rdata <= DATA_RST;
        else
            o_rdata <= mem_r[i_raddr];
    end
endmodule

// [sim/bchs_bus_model.sv]
// terminal-bus master model: frame clock, frame sync and serial data
`timescale 1ns/1ps
module bchs_bus_model (
    output logic      o_dclk,
    output logic      o_fsync,
    output logic      o_din,
    input  wire logic i_dout
);
    logic [31:0] rx_frame;

    ////////////////////////////////////////////////////////////
    // idle: clock stands still, data held high as if clamped
    initial begin
        o_dclk   = 1'b0;
        o_fsync  = 1'b0;
        o_din    = 1'b1;
        rx_frame = '0;
    end

    // one frame msb first; data moves before the rise, read back
    // late in the low phase since the switch resyncs the clock
    task automatic run_frame(input logic [31:0] tx);
        for (int i = 31; i >= 0; i--) begin
            o_fsync = (i == 31);
            o_din   = tx[i];
            #3 o_dclk = 1'b1;
            #80 o_dclk = 1'b0;
            #77 rx_frame[i] = i_dout;
        end
        o_fsync = 1'b0;
        o_din   = 1'b1;
    endtask
endmodule

// [sim/tb.sv]
// self-checking bench for the bearer/channel host switch
`timescale 1ns/1ps
module tb;
    import bchs_pkg::*;
    logic        sys_clk, sys_rst, pin_n, slave;
    logic        dclk, fsync, din, dout, h_wr, h_rd, stb, core_rst;
    logic [5:0]  h_addr;
    logic [7:0]  h_wdata, h_rdata;
    logic [31:0] core_rx, core_tx, fa, fc, hc, hb;
    int          n_errors = 0;
    int          cmp_count = 0;
    int          n_rst = 0;
    int          n_stb = 0;
    int          s;

    bchs_switch dut_u (.i_sys_clk(sys_clk), .i_sys_rst(sys_rst),
        .i_reset_input_pin_n(pin_n), .i_bus_slave_mode(slave),
        .i_bus_dclk(dclk), .i_bus_fsync(fsync), .i_bus_din(din),
        .o_bus_dout(dout), .i_host_addr(h_addr), .i_host_wdata(h_wdata),
        .i_host_wr(h_wr), .i_host_rd(h_rd), .o_host_rdata(h_rdata),
        .i_core_rx_frame(core_rx), .o_core_tx_frame(core_tx),
        .o_core_frame_stb(stb), .o_core_reset(core_rst));

    bchs_bus_model bus_u (.o_dclk(dclk), .o_fsync(fsync), .o_din(din),
        .i_dout(dout));

    ////////////////////////////////////////////////////////////
    // core reset pulses are counted, never assumed from timing
    always @(posedge sys_clk) begin
        if (core_rst === 1'b1) begin
            n_rst <= n_rst + 1;
        end
        if (stb === 1'b1) begin
            n_stb <= n_stb + 1;
        end
    end

    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        cmp_count++;
        if (g !== e) begin
            $display("Error %0t: byte %h expected %h", $time, g, e);
            n_errors++;
        end
    endtask

    task automatic chk32(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            $display("Error %0t: word %h expected %h", $time, g, e);
            n_errors++;
        end
    endtask

    task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        h_addr  <= a;
        h_wdata <= d;
        h_wr    <= 1'b1;
        @(posedge sys_clk);
        h_wr <= 1'b0;
    endtask

    // read data is registered, so look one edge after the strobe
    task automatic rd_chk(input logic [5:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        h_addr <= a;
        h_rd   <= 1'b1;
        @(posedge sys_clk);
        h_rd <= 1'b0;
        #1 chk8(h_rdata, e);
    endtask

    // frame outputs land a few cycles after the last falling edge
    task automatic frame(input logic [31:0] bt, input logic [31:0] ci);
        @(posedge sys_clk);
        core_rx <= ci;
        #5 bus_u.run_frame(bt);
        repeat (8) @(posedge sys_clk);
    endtask

    task automatic pin_pulse();
        @(posedge sys_clk);
        pin_n <= 1'b0;
        repeat (6) @(posedge sys_clk);
        pin_n <= 1'b1;
        repeat (10) @(posedge sys_clk);
    endtask

    function automatic logic [31:0] mk(input logic [7:0] b1, b2, mo,
                                       input logic [1:0] sg,
                                       input logic [3:0] ci);
        return {b1, b2, mo, sg, ci, IDLE_TAIL};
    endfunction

    task automatic wrap_up();
        if (n_errors == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    // a hung bus wait must still reach the verdict
    initial begin
        #400000;
        n_errors++;
        wrap_up();
    end

    initial begin
        {sys_rst, pin_n, slave, h_wr, h_rd} = 5'b11000;
        h_addr  = '0;
        h_wdata = '0;
        core_rx = '1;
        fa = mk(8'h12, 8'h34, 8'h56, 2'h2, 4'h5);
        fc = mk(8'h9A, 8'hBC, 8'hDE, 2'h1, 4'hA);
        hc = mk(8'hA0, 8'hA1, 8'hA2, 2'h3, 4'h4);
        hb = mk(8'hC0, 8'hC1, 8'hC2, 2'h3, 4'h4);
        repeat (3) @(posedge sys_clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge sys_clk);
        // host port alone: bus input clamped, output unread
        rd_chk(A_SWSEL, 8'h00);
        rd_chk(A_STATUS, 8'h00);
        rd_chk(A_CORE_RX, 8'hFF);
        rd_chk(A_BUS_RX + 6'h01, 8'hFF);
        rd_chk(6'h3F, 8'h00);
        chk32(32'(n_rst), 32'd1);
        // straight-through paths both ways
        s = n_stb;
        frame(fa, fc);
        chk32(core_tx, fa);
        chk32(32'(n_stb - s), 32'd1);
        frame(fa, fc);
        chk32(bus_u.rx_frame, fc);
        rd_chk(A_STATUS, 8'h00);
        // all five channels through the host registers
        wr_reg(A_SWSEL, 8'h7C);
        for (int c = 0; c < NCH; c++) begin
            wr_reg(A_CORE_TX + 6'(c), 8'hA0 + 8'(c));
            wr_reg(A_BUS_TX + 6'(c), 8'hC0 + 8'(c));
        end
        frame(fa, fc);
        chk32(core_tx, hc);
        rd_chk(A_STATUS, 8'h03);
        rd_chk(A_CORE_RX, 8'h9A);
        repeat (50) @(posedge sys_clk);
        rd_chk(A_CORE_RX, 8'h9A);
        rd_chk(A_STATUS, 8'h03);
        rd_chk(A_BUS_RX, 8'h12);
        repeat (3) @(posedge sys_clk);
        rd_chk(A_STATUS, 8'h02);
        rd_chk(A_BUS_RX + 6'h01, 8'h34);
        rd_chk(A_CORE_RX + 6'h01, 8'hBC);
        repeat (3) @(posedge sys_clk);
        rd_chk(A_STATUS, 8'h00);
        rd_chk(A_BUS_RX + 6'h02, 8'h56);
        rd_chk(A_CORE_RX + 6'h04, 8'h0A);
        frame(fa, fc);
        chk32(bus_u.rx_frame, hb);
        frame(fa, fc);
        chk32(core_tx, hc);
        chk32(bus_u.rx_frame, hb);
        // pin reset spares the startup register only
        wr_reg(A_CFG, 8'hA5);
        s = n_rst;
        pin_pulse();
        chk32(32'(n_rst - s), 32'd1);
        rd_chk(A_SWSEL, 8'h00);
        rd_chk(A_CFG, 8'hA5);
        rd_chk(A_CORE_RX, 8'hFF);
        // command code to the core resets the core only
        s = n_rst;
        frame(mk(8'h00, 8'h00, 8'h00, 2'h0, CI_SW_RESET), fc);
        chk32(32'(n_rst - s), 32'd1);
        rd_chk(A_CFG, 8'hA5);
        // slave mode: no core reset while the bus clock is absent
        slave <= 1'b1;
        // let the clock-loss watch see the bus clock gone first
        repeat (60) @(posedge sys_clk);
        s = n_rst;
        pin_pulse();
        repeat (100) @(posedge sys_clk);
        chk32(32'(n_rst - s), 32'd0);
        frame(fa, fc);
        chk32(32'(n_rst - s), 32'd1);
        // power-on reset clears the startup register too
        sys_rst <= 1'b1;
        slave   <= 1'b0;
        repeat (3) @(posedge sys_clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge sys_clk);
        rd_chk(A_CFG, 8'h00);
        wrap_up();
    end
endmodule
